/* File: mwsf_adc_model.sv */
/* column adc stand-in: answers each read strobe one cycle later.
   assumes the strobe and reference flag come on mclk. */
`timescale 1ns/100ps
`default_nettype none
module mwsf_adc_model (
	// clock and request
	input wire logic         mclk,
	input wire logic         readStrobe,
	input wire logic         refColumns,
	// conversion result
	output logic [11:0][9:0] adcData
);
	// reference reads low, image higher; stale data toggles
	initial adcData = '0;
	always @(posedge mclk)
		adcData <= readStrobe ? {12{refColumns ? 10'h010 : 10'h050}} : ~adcData;
endmodule // mwsf_adc_model
`default_nettype wire

/* File: mwsf_ahb_regs.sv */
/*
 * ahb-lite slave register file, zero wait state, word access only.
 * assumes a single master; decode uses haddr[7:0] inside the hsel region.
 */
`timescale 1ns/100ps
`default_nettype none
module mwsf_ahb_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// towards sequencer
	mwsf_cfg_if.regs         cfg
);
	logic [7:0]  ctrl, seq1, seq3;
	logic [1:0]  nwin;
	logic [15:0] tint, dsStamp, tsStamp, blackTime, resLen;
	logic [7:0]  chanCtl [mwsf_pkg::CHAN_REGS];
	logic [31:0] winWord [2*mwsf_pkg::MAX_WIN];
	logic        wrPend;
	logic [7:0]  wrAddr;

	// address phase and decode
	wire logic       addrPhase = hsel & htrans[1] & hready;
	wire logic [7:0] rdA       = haddr[7:0];
	wire logic       chanR     = rdA[7:6] == 2'b01 && rdA[5:2] < 4'(mwsf_pkg::CHAN_REGS);
	wire logic       winR      = rdA[7:5] == 3'b100;
	wire logic       chanW     = wrAddr[7:6] == 2'b01 && wrAddr[5:2] < 4'(mwsf_pkg::CHAN_REGS);
	wire logic       winW      = wrAddr[7:5] == 3'b100;
	wire logic [31:0] statusWord = {cfg.frameCnt, 11'h0, cfg.winIdx, cfg.state};
	wire logic [31:0] rdWord =
		chanR ? {24'h0, chanCtl[rdA[5:2]]} :
		winR ? winWord[rdA[4:2]] :
		rdA == mwsf_pkg::A_CTRL ? {24'h0, ctrl} :
		rdA == mwsf_pkg::A_SEQ1 ? {24'h0, seq1} :
		rdA == mwsf_pkg::A_SEQ3 ? {24'h0, seq3} :
		rdA == mwsf_pkg::A_NWIN ? {30'h0, nwin} :
		rdA == mwsf_pkg::A_TINT ? {16'h0, tint} :
		rdA == mwsf_pkg::A_DS ? {16'h0, dsStamp} :
		rdA == mwsf_pkg::A_TS ? {16'h0, tsStamp} :
		rdA == mwsf_pkg::A_BLACK ? {16'h0, blackTime} :
		rdA == mwsf_pkg::A_RESLEN ? {16'h0, resLen} :
		rdA == mwsf_pkg::A_STATUS ? statusWord : 32'h0;

	////////////////////////////////////////////////////////////////
	// bus handshake, read capture and register writes
	always_ff @(posedge mclk) begin
		if (srst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= '0;
			wrPend <= 1'b0;
			wrAddr <= '0;
			ctrl <= '0;
			seq1 <= mwsf_pkg::SEQ1_RST;
			seq3 <= mwsf_pkg::SEQ3_RST;
			nwin <= '0;
			tint <= mwsf_pkg::TINT_RST;
			dsStamp <= mwsf_pkg::DS_RST;
			tsStamp <= mwsf_pkg::TS_RST;
			blackTime <= mwsf_pkg::BLACK_RST;
			resLen <= mwsf_pkg::RESLEN_RST;
			for (int i = 0; i < mwsf_pkg::CHAN_REGS; i++) chanCtl[i] <= '0;
			for (int i = 0; i < 2*mwsf_pkg::MAX_WIN; i++) winWord[i] <= '0;
		end else begin
			hreadyout <= 1'b1;
			wrPend <= addrPhase & hwrite;
			wrAddr <= rdA;
			if (addrPhase && !hwrite) hrdata <= rdWord;
			if (wrPend) begin
				if (chanW) chanCtl[wrAddr[5:2]] <= hwdata[7:0];
				// word0 keeps two 10-bit rows, word1 two 6-bit slot fields
				if (winW) winWord[wrAddr[4:2]] <= hwdata & (wrAddr[2] ? 32'h003f_003f : 32'h03ff_03ff);
				unique case (wrAddr)
					mwsf_pkg::A_CTRL: ctrl <= hwdata[7:0];
					mwsf_pkg::A_SEQ1: seq1 <= hwdata[7:0];
					mwsf_pkg::A_SEQ3: seq3 <= hwdata[7:0];
					mwsf_pkg::A_NWIN: nwin <= hwdata[1:0];
					mwsf_pkg::A_TINT: tint <= hwdata[15:0];
					mwsf_pkg::A_DS: dsStamp <= hwdata[15:0];
					mwsf_pkg::A_TS: tsStamp <= hwdata[15:0];
					mwsf_pkg::A_BLACK: blackTime <= hwdata[15:0];
					mwsf_pkg::A_RESLEN: resLen <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// configuration fields
	assign cfg.run = ctrl[mwsf_pkg::CTRL_RUN];
	assign cfg.lineUnit = seq1[mwsf_pkg::SEQ1_LINES];
	assign cfg.slave = seq1[mwsf_pkg::SEQ1_SLAVE];
	assign cfg.full = seq1[mwsf_pkg::SEQ1_FULL];
	assign cfg.dsEn = seq1[mwsf_pkg::SEQ1_DS];
	assign cfg.tsEn = seq1[mwsf_pkg::SEQ1_TS];
	assign cfg.refGen = seq3[mwsf_pkg::SEQ3_REFGEN];
	assign cfg.numWin = nwin;
	assign cfg.tint = tint;
	assign cfg.dsStamp = dsStamp;
	assign cfg.tsStamp = tsStamp;
	assign cfg.blackTime = blackTime;
	assign cfg.resLen = resLen;
	always_comb begin
		for (int c = 0; c < mwsf_pkg::CHANNELS; c++) cfg.fpnEn[c] = chanCtl[c][mwsf_pkg::CHAN_FPN];
		for (int w = 0; w < mwsf_pkg::MAX_WIN; w++) begin
			cfg.yStart[w] = winWord[2*w][9:0];
			cfg.yEnd[w] = winWord[2*w][mwsf_pkg::HI_LSB +: 10];
			cfg.xStart[w] = winWord[2*w+1][5:0];
			cfg.xKern[w] = winWord[2*w+1][mwsf_pkg::HI_LSB +: 6];
		end
	end
endmodule // mwsf_ahb_regs
`default_nettype wire

/* File: mwsf_cfg_if.sv */
/*
 * configuration and status bundle between register file and sequencer.
 * assumes both ends on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface mwsf_cfg_if;
	logic              run, lineUnit, slave, full, dsEn, tsEn, refGen;
	logic [1:0]        numWin;
	logic [15:0]       tint, dsStamp, tsStamp, blackTime, resLen;
	logic [11:0]       fpnEn;
	logic [3:0][9:0]   yStart, yEnd;
	logic [3:0][5:0]   xStart, xKern;
	logic [2:0]        state;
	logic [1:0]        winIdx;
	logic [15:0]       frameCnt;
	modport regs (output run, lineUnit, slave, full, dsEn, tsEn, refGen, numWin, tint, dsStamp, tsStamp,
		blackTime, resLen, fpnEn, yStart, yEnd, xStart, xKern, input state, winIdx, frameCnt);
	modport seq (input run, lineUnit, slave, full, dsEn, tsEn, refGen, numWin, tint, dsStamp, tsStamp,
		blackTime, resLen, fpnEn, yStart, yEnd, xStart, xKern, output state, winIdx, frameCnt);
endinterface
`default_nettype wire

/* File: mwsf_fpn_corr.sv */
/*
 * column offset memory and per-channel subtraction.
 * assumes pixel data and tags on mclk, one slot per valid.
 */
`timescale 1ns/100ps
`default_nettype none
module mwsf_fpn_corr #(
	parameter int CH = mwsf_pkg::CHANNELS,
	parameter int PW = mwsf_pkg::PIX_W,
	parameter int NS = mwsf_pkg::SLOTS
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// incoming slot
	input  wire logic                 inValid,
	input  wire logic                 isRef,
	input  wire logic [5:0]           slot,
	input  wire logic [CH-1:0][PW-1:0] pixIn,
	input  wire logic [CH-1:0]        enable,
	// corrected slot
	output logic                      outValid,
	output logic [CH-1:0][PW-1:0]     pixOut
);
	logic [PW-1:0] offsetMem [NS][CH];

	// clamp at zero so a dark pixel never wraps
	function automatic logic [PW-1:0] subSat(input logic [PW-1:0] a, input logic [PW-1:0] b);
		return (a > b) ? PW'(a - b) : '0;
	endfunction

	////////////////////////////////////////////////////////////////
	// reference line capture
	always_ff @(posedge mclk) begin
		if (inValid && isRef) begin
			for (int c = 0; c < CH; c++) offsetMem[slot][c] <= pixIn[c];
		end
	end

	// subtract stored offset where the channel asks for it
	always_ff @(posedge mclk) begin
		if (srst) begin
			outValid <= 1'b0;
			pixOut   <= '0;
		end else begin
			outValid <= inValid;
			for (int c = 0; c < CH; c++)
				pixOut[c] <= (enable[c] && !isRef) ? subSat(pixIn[c], offsetMem[slot][c]) : pixIn[c];
		end
	end
endmodule // mwsf_fpn_corr
`default_nettype wire

/* File: mwsf_pkg.sv */
/*
 * constants, register map and state type of the multi window readout sequencer.
 * assumes one 10 MHz clock and a synchronous active-high reset in every user.
 */
// Overview of operation
// - windows read strictly in order, one by one
// - one to four windows chosen by software
// - every window goes out as own frame
// - overhead period first, then each window's lines
// - integration capped at sum of window heights in line-unit mode
// - second and third pixel reset at programmed stamps
// - master slope resets enabled by mode bits 5,6
// - slave mode follows three pins, ignores timers
// - reference line read first, stored per column
// - stored column offset subtracted from each pixel
// - correction enabled per channel, control bit 1
// - mode three bit 2 enables reference line
// - last slot carries pixels plus calibration columns
// - grey and black columns get minimal integration
// - full frame mode reads whole array
// - 12 pixels per clock, 24 column granularity
package mwsf_pkg;
	////////////////////////////////////////////////////////////////
	// array geometry
	localparam int CHANNELS     = 12;
	localparam int PIX_W        = 10;
	localparam int ROWS         = 1024;
	localparam int SLOTS        = 54;
	localparam int MAX_WIN      = 4;
	localparam int PIX_PER_SLOT = 24;
	localparam int CHAN_REGS    = 13;
	localparam logic [5:0] LAST_PIX_SLOT = 6'(SLOTS - 2);
	localparam logic [5:0] CAL_SLOT      = 6'(SLOTS - 1);
	localparam logic [9:0] ROW_LAST      = 10'(ROWS - 1);
	////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_SEQ1   = 8'h04;
	localparam logic [7:0] A_SEQ3   = 8'h08;
	localparam logic [7:0] A_NWIN   = 8'h0c;
	localparam logic [7:0] A_TINT   = 8'h10;
	localparam logic [7:0] A_DS     = 8'h14;
	localparam logic [7:0] A_TS     = 8'h18;
	localparam logic [7:0] A_BLACK  = 8'h1c;
	localparam logic [7:0] A_RESLEN = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	localparam logic [7:0] A_CHAN   = 8'h40;
	localparam logic [7:0] A_WIN    = 8'h80;
	////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_RUN    = 0;
	localparam int SEQ1_LINES  = 0;
	localparam int SEQ1_SLAVE  = 1;
	localparam int SEQ1_FULL   = 2;
	localparam int SEQ1_DS     = 5;
	localparam int SEQ1_TS     = 6;
	localparam int SEQ3_REFGEN = 2;
	localparam int CHAN_FPN    = 1;
	localparam int HI_LSB      = 16;
	////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic [7:0]  SEQ1_RST   = 8'h00;
	localparam logic [7:0]  SEQ3_RST   = 8'h04;
	localparam logic [15:0] TINT_RST   = 16'h0100;
	localparam logic [15:0] DS_RST     = 16'h00e6;
	localparam logic [15:0] TS_RST     = 16'h00fd;
	localparam logic [15:0] BLACK_RST  = 16'h0004;
	localparam logic [15:0] RESLEN_RST = 16'h0008;
	localparam logic [15:0] FOT_SLOTS  = 16'h0010;
	////////////////////////////////////////////////////////////////
	// sync channel words
	localparam logic [9:0] SYNC_IDLE = 10'h000;
	localparam logic [9:0] SYNC_DATA = 10'h035;
	localparam logic [9:0] SYNC_FS   = 10'h2a0;
	localparam logic [9:0] SYNC_LS   = 10'h2a1;
	localparam logic [9:0] SYNC_CAL  = 10'h2a2;
	localparam logic [9:0] SYNC_FE   = 10'h2a3;
	localparam logic [9:0] SYNC_REF  = 10'h2a4;
	////////////////////////////////////////////////////////////////
	// sequencer states, gray along the frame loop
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RST  = 3'b001,
		S_EXPO = 3'b011,
		S_FOT  = 3'b010,
		S_REF  = 3'b110,
		S_LINE = 3'b111,
		S_CAL  = 3'b101,
		S_WEND = 3'b100
	} mwsf_state_t;
endpackage

/* File: mwsf_readout.sv */
/*
 * readout sequencer top: exposure with slope resets, window walk, reference line,
 * offset correction and sync channel.
 * assumes linkClk paces one slot per rising edge and column adc data arrive the
 * cycle after readStrobe.
 */
`timescale 1ns/100ps
`default_nettype none
module mwsf_readout (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  srst,
	// ahb-lite register bus
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// link clock and slave exposure pins
	input  wire logic                  linkClk,
	input  wire logic                  intTimePin,
	input  wire logic                  doubleSlopeResetPin,
	input  wire logic                  tripleSlopeResetPin,
	// pixel array and column adcs
	input  wire logic [mwsf_pkg::CHANNELS-1:0][mwsf_pkg::PIX_W-1:0] adcData,
	output logic                       readStrobe,
	output logic [9:0]                 rowAddr,
	output logic [5:0]                 colSlot,
	output logic                       refColumns,
	output logic                       calSlot,
	// exposure control
	output logic                       pixelReset,
	output logic                       dsReset,
	output logic                       tsReset,
	output logic                       greyGate,
	// data and sync channels
	output logic [mwsf_pkg::CHANNELS-1:0][mwsf_pkg::PIX_W-1:0] chanData,
	output logic [9:0]                 syncWord,
	output logic                       dataValid
);
	mwsf_cfg_if cfg ();

	mwsf_ahb_regs u_regs (
		.mclk(mclk),
		.srst(srst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.cfg(cfg.regs)
	);

	////////////////////////////////////////////////////////////////
	// pin synchronisers: link clock, integration, ds, ts
	logic [3:0] pinMeta, pinSync, pinLast;
	wire logic [3:0] pinRaw = {tripleSlopeResetPin, doubleSlopeResetPin, intTimePin, linkClk};

	always_ff @(posedge mclk) begin
		if (srst) begin
			pinMeta <= '0;
			pinSync <= '0;
			pinLast <= '0;
		end else begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	// edges seen on the second stage only
	wire logic [3:0] pinRise = pinSync & ~pinLast;
	wire logic       intFall = pinLast[1] & ~pinSync[1];
	wire logic       linkRise = pinRise[0];

	////////////////////////////////////////////////////////////////
	// sequencer state
	mwsf_pkg::mwsf_state_t state, next_state;
	logic [15:0] cnt, frameCnt;
	logic [9:0]  row;
	logic [5:0]  slot;
	logic [1:0]  win;
	logic        newWin;
	logic [6:0]  lineDiv;
	logic [9:0]  syncReq, tagSync;
	logic        tagValid, tagRef;
	logic [5:0]  tagSlot;

	function automatic logic [12:0] winHeight(input logic [9:0] ys, input logic [9:0] ye);
		return (ye >= ys) ? 13'(ye - ys) + 13'h1 : 13'h1;
	endfunction

	// current window, full frame overrides the window table
	wire logic [9:0] curYs = cfg.full ? 10'h0 : cfg.yStart[win];
	wire logic [9:0] curYe = cfg.full ? mwsf_pkg::ROW_LAST : cfg.yEnd[win];
	wire logic [5:0] curXs = cfg.full ? 6'h0 : cfg.xStart[win];
	wire logic [5:0] curXk = cfg.full ? mwsf_pkg::CAL_SLOT : cfg.xKern[win];
	wire logic [5:0] kEff = (curXk == 6'h0) ? 6'h1 : curXk;
	wire logic [6:0] pixEnd = 7'(curXs) + 7'(kEff) - 7'h1;
	wire logic [5:0] lastPix = (pixEnd > 7'(mwsf_pkg::LAST_PIX_SLOT)) ? mwsf_pkg::LAST_PIX_SLOT : pixEnd[5:0];
	wire logic       lastWin = cfg.full || (win == cfg.numWin);

	// sum of heights of the windows in use
	logic [12:0] heightSum;
	always_comb begin
		heightSum = 13'h0;
		for (int w = 0; w < mwsf_pkg::MAX_WIN; w++)
			if (w <= int'(cfg.numWin)) heightSum = heightSum + winHeight(cfg.yStart[w], cfg.yEnd[w]);
		if (cfg.full) heightSum = 13'(mwsf_pkg::ROWS);
	end

	// integration limit in line units
	wire logic [15:0] tintEff = (cfg.lineUnit && cfg.tint > 16'(heightSum)) ? 16'(heightSum) : cfg.tint;

	// line tick from the first window's slot count, or from all slots in full frame
	wire logic [6:0] lineLen = cfg.full ? 7'(mwsf_pkg::SLOTS) : 7'(cfg.xKern[0]) + 7'h1;
	wire logic       lineTick = linkRise && (lineDiv + 7'h1 >= lineLen);
	wire logic       timeTick = cfg.lineUnit ? lineTick : 1'b1;

	// request and sync decode
	wire logic reqFire = linkRise && (state == mwsf_pkg::S_REF || state == mwsf_pkg::S_CAL
		|| (state == mwsf_pkg::S_LINE && !newWin));
	wire logic syncFire = reqFire || (linkRise && state == mwsf_pkg::S_WEND);
	wire logic [9:0] lineSync = (slot != curXs) ? mwsf_pkg::SYNC_DATA :
		(row == curYs) ? mwsf_pkg::SYNC_FS : mwsf_pkg::SYNC_LS;
	wire logic [9:0] syncNow =
		state == mwsf_pkg::S_REF ? mwsf_pkg::SYNC_REF :
		state == mwsf_pkg::S_LINE ? lineSync :
		state == mwsf_pkg::S_CAL ? mwsf_pkg::SYNC_CAL : mwsf_pkg::SYNC_FE;
	wire logic cntInc = (state == mwsf_pkg::S_RST) || (state == mwsf_pkg::S_EXPO && timeTick)
		|| (state == mwsf_pkg::S_FOT && linkRise);
	wire logic stateChange = next_state != state;
	wire logic expoMaster = state == mwsf_pkg::S_EXPO && !cfg.slave;

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			mwsf_pkg::S_IDLE:
				if (cfg.run && (!cfg.slave || pinRise[1])) next_state = mwsf_pkg::S_RST;
			mwsf_pkg::S_RST:
				if (cfg.slave || cnt + 16'h1 >= cfg.resLen) next_state = mwsf_pkg::S_EXPO;
			mwsf_pkg::S_EXPO:
				if (cfg.slave ? intFall : (timeTick && cnt + 16'h1 >= tintEff)) next_state = mwsf_pkg::S_FOT;
			mwsf_pkg::S_FOT:
				if (linkRise && cnt + 16'h1 >= mwsf_pkg::FOT_SLOTS)
					next_state = cfg.refGen ? mwsf_pkg::S_REF : mwsf_pkg::S_LINE;
			mwsf_pkg::S_REF:
				if (linkRise && slot == mwsf_pkg::CAL_SLOT) next_state = mwsf_pkg::S_LINE;
			mwsf_pkg::S_LINE:
				if (reqFire && slot >= lastPix) next_state = mwsf_pkg::S_CAL;
			mwsf_pkg::S_CAL:
				if (linkRise) next_state = (row == curYe) ? mwsf_pkg::S_WEND : mwsf_pkg::S_LINE;
			mwsf_pkg::S_WEND:
				if (linkRise) next_state = lastWin ? mwsf_pkg::S_IDLE : mwsf_pkg::S_LINE;
		endcase
	end

	// state, timer and line divider
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= mwsf_pkg::S_IDLE;
			cnt <= '0;
			lineDiv <= '0;
		end else begin
			state <= next_state;
			cnt <= stateChange ? 16'h0 : cnt + {15'h0, cntInc};
			lineDiv <= (stateChange || lineTick) ? 7'h0 : lineDiv + {6'h0, linkRise};
		end
	end

	// window, row and slot walk
	always_ff @(posedge mclk) begin
		if (srst) begin
			row <= '0;
			slot <= '0;
			win <= '0;
			newWin <= 1'b0;
			frameCnt <= '0;
		end else if (state == mwsf_pkg::S_FOT) begin
			slot <= 6'h0;
			win <= 2'h0;
			newWin <= 1'b1;
		end else if (state == mwsf_pkg::S_LINE && newWin) begin
			row <= curYs;
			slot <= curXs;
			newWin <= 1'b0;
		end else if (linkRise) begin
			if (state == mwsf_pkg::S_REF || state == mwsf_pkg::S_LINE) slot <= slot + 6'h1;
			if (state == mwsf_pkg::S_CAL && row != curYe) begin
				row <= row + 10'h1;
				slot <= curXs;
			end
			if (state == mwsf_pkg::S_WEND && !lastWin) begin
				win <= win + 2'h1;
				newWin <= 1'b1;
			end
			if (state == mwsf_pkg::S_WEND && lastWin) frameCnt <= frameCnt + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// array requests, the calibration slot closes every line
	always_ff @(posedge mclk) begin
		if (srst) begin
			readStrobe <= 1'b0;
			rowAddr <= '0;
			colSlot <= '0;
			refColumns <= 1'b0;
			calSlot <= 1'b0;
			syncReq <= mwsf_pkg::SYNC_IDLE;
		end else begin
			readStrobe <= reqFire;
			refColumns <= reqFire && state == mwsf_pkg::S_REF;
			calSlot <= reqFire && state == mwsf_pkg::S_CAL;
			syncReq <= syncFire ? syncNow : mwsf_pkg::SYNC_IDLE;
			if (reqFire) begin
				rowAddr <= row;
				colSlot <= (state == mwsf_pkg::S_CAL) ? mwsf_pkg::CAL_SLOT : slot;
			end
		end
	end

	// exposure: initial reset, slope resets, grey column gate
	always_ff @(posedge mclk) begin
		if (srst) begin
			pixelReset <= 1'b0;
			dsReset <= 1'b0;
			tsReset <= 1'b0;
			greyGate <= 1'b0;
		end else begin
			pixelReset <= state == mwsf_pkg::S_RST;
			dsReset <= cfg.slave ? (state == mwsf_pkg::S_EXPO && pinRise[2]) :
				(expoMaster && cfg.dsEn && timeTick && cnt == cfg.dsStamp);
			tsReset <= cfg.slave ? (state == mwsf_pkg::S_EXPO && pinRise[3]) :
				(expoMaster && cfg.tsEn && timeTick && cnt == cfg.tsStamp);
			greyGate <= expoMaster && tintEff >= cnt && (tintEff - cnt) <= cfg.blackTime;
		end
	end

	// pipeline tags to the adc return cycle, sync aligned with data
	always_ff @(posedge mclk) begin
		if (srst) begin
			tagValid <= 1'b0;
			tagRef <= 1'b0;
			tagSlot <= '0;
			tagSync <= mwsf_pkg::SYNC_IDLE;
			syncWord <= mwsf_pkg::SYNC_IDLE;
		end else begin
			tagValid <= readStrobe;
			tagRef <= refColumns;
			tagSlot <= colSlot;
			tagSync <= syncReq;
			syncWord <= tagSync;
		end
	end

	mwsf_fpn_corr u_fpn (
		.mclk(mclk),
		.srst(srst),
		.inValid(tagValid),
		.isRef(tagRef),
		.slot(tagSlot),
		.pixIn(adcData),
		.enable(cfg.fpnEn),
		.outValid(dataValid),
		.pixOut(chanData)
	);

	// status back to the register file
	assign cfg.state = state;
	assign cfg.winIdx = win;
	assign cfg.frameCnt = frameCnt;
endmodule // mwsf_readout
`default_nettype wire

/* File: mwsf_readout_checker.sv */
/* port assertions for the readout sequencer.
   assumes binding into mwsf_readout, one mclk domain. */
`timescale 1ns/100ps
`default_nettype none
module mwsf_readout_checker (
	// clock and reset
	input wire logic       mclk,
	input wire logic       srst,
	// watched outputs
	input wire logic       readStrobe,
	input wire logic       dataValid,
	input wire logic       refColumns,
	input wire logic       calSlot,
	input wire logic       pixelReset,
	input wire logic       dsReset,
	input wire logic       tsReset,
	input wire logic [5:0] colSlot,
	input wire logic [9:0] rowAddr,
	input wire logic [9:0] syncWord
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	////////////////////////////////
	// slot pacing and pipeline
	strobe_single_a: assert property (readStrobe |=> !readStrobe) else $error("strobe too long");
	valid_lag_a: assert property (readStrobe |-> ##2 dataValid) else $error("valid late");
	row_hold_a: assert property (!readStrobe |-> $stable(rowAddr)) else $error("row moved");
	reset_first_a: assert property (pixelReset |-> !readStrobe) else $error("read in reset");
	// calibration slot and reference line
	cal_slot_a: assert property (calSlot |-> readStrobe && colSlot == mwsf_pkg::CAL_SLOT) else $error("cal slot");
	cal_sync_a: assert property (calSlot && !refColumns |-> ##2 syncWord == mwsf_pkg::SYNC_CAL) else $error("cal sync");
	ref_sync_a: assert property (refColumns |-> ##2 syncWord == mwsf_pkg::SYNC_REF) else $error("ref sync");
	// slope resets are single pulses
	ds_pulse_a: assert property (dsReset |=> !dsReset) else $error("ds pulse");
	ts_pulse_a: assert property (tsReset |=> !tsReset) else $error("ts pulse");
	cover property (dsReset);
	cover property (tsReset);
	cover property (calSlot);
	cover property (refColumns);
endmodule // mwsf_readout_checker
bind mwsf_readout mwsf_readout_checker mwsf_readout_checker_i (.mclk, .srst, .readStrobe, .dataValid,
	.refColumns, .calSlot, .pixelReset, .dsReset, .tsReset, .colSlot, .rowAddr, .syncWord);
`default_nettype wire

/* File: testbench.sv */
/* two-window frame through ahb setup, slope resets, offset correction.
   assumes the adc model answers the strobes. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic mclk = 1'b0, srst = 1'b1, linkClk = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
	logic hreadyout, readStrobe, refColumns, calSlot, dsReset, tsReset, dataValid, greyGate;
	logic intPin = 1'b0, dsPin = 1'b0, tsPin = 1'b0;
	localparam int BLACK_TGT = 'h50; // nonzero black target
	logic [9:0] rowAddr, syncWord;
	logic [11:0][9:0] chanData, adcData;
	int numErrors = 0, testsRun = 0, dsN = 0, tsN = 0, refN = 0, calN = 0, fsN = 0, n;
	int greyN = 0, calSum = 0;
	logic [9:0] rows[$], d0[$], d1[$];
	int refs[$];
	// timers in clock units, stamps near 90 and 99 percent
	logic [7:0] cfgA[13] = '{8'h20, 8'h10, 8'h14, 8'h18, 8'h04, 8'h0c, 8'h80, 8'h84, 8'h88, 8'h8c,
		8'h40, 8'h44, 8'h00}; // mode three and black time left alone
	logic [31:0] cfgD[13] = '{2, 32'h60, 32'h56, 32'h5f, 32'h60, 1, 32'h60005, 32'h10000, 32'h20002,
		32'h10001, 2, 0, 1}; // readout below reset plus integration
	////////////////////////////////
	mwsf_readout mwsf_readout_i (.mclk, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .linkClk, .intTimePin(intPin),
		.doubleSlopeResetPin(dsPin), .tripleSlopeResetPin(tsPin), .adcData, .readStrobe, .rowAddr,
		.colSlot(), .refColumns, .calSlot, .pixelReset(), .dsReset, .tsReset, .greyGate,
		.chanData, .syncWord, .dataValid);
	mwsf_adc_model mwsf_adc_model_i (.mclk, .readStrobe, .refColumns, .adcData);
	// clocks, link unrelated in phase
	initial forever #50 mclk = ~mclk;
	initial begin
		#137;
		forever #400 linkClk = ~linkClk;
	end
	////////////////////////////////
	task automatic stopTest();
		$display("errors %0d of %0d checks", numErrors, testsRun);
		if (numErrors == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// one single ahb transfer, bounded waits
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1 && ++k < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1 && ++k < 50);
		rdv = hrdata;
		if (k >= 50) begin
			chk(k, 0);
			stopTest();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	////////////////////////////////
	// stream monitor
	always @(posedge mclk) if (!srst) begin
		if (dsReset) dsN++;
		if (tsReset) tsN++;
		if (greyGate) greyN++;
		if (dataValid && syncWord === mwsf_pkg::SYNC_CAL) calSum += chanData[1];
		if (dataValid && syncWord === mwsf_pkg::SYNC_FS) fsN++;
		if (readStrobe && refColumns) refN++;
		else if (readStrobe && calSlot) calN++;
		else if (readStrobe) begin
			rows.push_back(rowAddr);
			refs.push_back(refN);
		end
		if (dataValid && syncWord !== mwsf_pkg::SYNC_REF) begin
			d0.push_back(chanData[0]);
			d1.push_back(chanData[1]);
		end
	end
	// pass 0 master frame, pass 1 slave frame after a reset in mid-run
	initial begin
		for (int p = 0; p < 2; p++) begin
			srst <= 1'b1;
			repeat (2) @(posedge mclk);
			srst <= 1'b0;
			@(posedge mclk);
			rd(mwsf_pkg::A_SEQ3, 32'(mwsf_pkg::SEQ3_RST));
			rd(mwsf_pkg::A_TINT, 32'(mwsf_pkg::TINT_RST));
			rd(8'hfc, 32'h0);
			// two windows, both slopes, offset on channel 0 only
			cfgD[4] = p ? 32'h62 : 32'h60;
			foreach (cfgA[i]) xfer(1'b1, cfgA[i], cfgD[i]);
			if (p) begin
				intPin <= 1'b1;
				repeat (8) @(posedge mclk);
				dsPin <= 1'b1;
				repeat (8) @(posedge mclk);
				tsPin <= 1'b1;
				repeat (8) @(posedge mclk);
				intPin <= 1'b0;
				dsPin <= 1'b0;
				tsPin <= 1'b0;
			end
			for (n = 0; n < 20000 && calN < 3 * (p + 1); n++) @(posedge mclk);
			repeat (4) @(posedge mclk);
			chk(calN, 3 * (p + 1));
			chk(fsN, 2 * (p + 1));
			chk(rows[3 * p], 5);
			chk(rows[3 * p + 1], 6);
			chk(rows[3 * p + 2], 2);
			chk(refs[3 * p], mwsf_pkg::SLOTS * (p + 1));
			chk(dsN, p + 1);
			chk(tsN, p + 1);
			chk(d0[6 * p], 10'h040);
			chk(d1[6 * p], 10'h050);
			chk(greyN, mwsf_pkg::BLACK_RST);
			chk(calSum, calN * BLACK_TGT);
		end
		stopTest();
	end
endmodule // testbench
`default_nettype wire
